// >>> hdl/lsfs_interval_timer.sv
// One-shot interval timer counting system clock cycles.
// Assumes start is a single-cycle request from the supervisor; clear may stay high for as long as the interval is not wanted.
`timescale 1ns/1ps
module lsfs_interval_timer #(
  parameter int unsigned LOAD = lsfs_pkg::BLANK_CYCLES
) (
  input  wire logic clk_sys,
  input  wire logic rst,
  input  wire logic start,
  input  wire logic clear,
  output logic      expired
);

  // A zero interval or one that overflows the counter cannot be served.
  if (LOAD == 0 || LOAD > (2 ** lsfs_pkg::TMR_W)) begin : g_bad_load
    $error("Interval timer load out of range.");
  end

  localparam logic [lsfs_pkg::TMR_W-1:0] LOAD_M1 = lsfs_pkg::TMR_W'(LOAD - 1);

  lsfs_pkg::lsfs_timer_s tmr_q;
  lsfs_pkg::lsfs_timer_s tmr_d;

  // Expiry lands on the LOAD-th cycle after start, so the interval is never short.
  assign expired = tmr_q.running && (tmr_q.count == '0);

  // Clear wins over start, so an aborted interval always restarts from its full length.
  always_comb begin
    tmr_d = tmr_q;
    if (clear) begin
      tmr_d.running = 1'b0;
      tmr_d.count   = '0;
    end else if (start) begin
      tmr_d.running = 1'b1;
      tmr_d.count   = LOAD_M1;
    end else if (tmr_q.running) begin
      if (tmr_q.count == '0) begin
        tmr_d.running = 1'b0;
      end else begin
        tmr_d.count = tmr_q.count - 1'b1;
      end
    end
  end

  // State register.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      tmr_q <= '0;
    end else begin
      tmr_q <= tmr_d;
    end
  end

endmodule

// >>> hdl/lsfs_pkg.sv
// Shared constants and types for the load switch fault supervisor.
// Assumes a single 50 MHz system clock and a synchronous active-high reset.
package lsfs_pkg;

  // System clock rate in kHz; kHz keeps the products below two to the thirty-first.
  localparam int unsigned CLK_KHZ = 50000;

  // Interval minima in milliseconds and their cycle counts.
  localparam int unsigned BLANK_MS     = 100;
  localparam int unsigned RETRY_MS     = 1500;
  localparam int unsigned BLANK_CYCLES = BLANK_MS * CLK_KHZ;
  localparam int unsigned RETRY_CYCLES = RETRY_MS * CLK_KHZ;

  // Width of the interval counters; wide enough for the retry interval.
  localparam int unsigned TMR_W = 27;

  // Register map, byte addresses on the Wishbone bus.
  localparam int unsigned ADR_W = 4;
  localparam logic [ADR_W-1:0] ADR_CTRL   = 4'h0;
  localparam logic [ADR_W-1:0] ADR_STATUS = 4'h4;

  // Control register layout and reset value.
  localparam int unsigned CTRL_TRIM_BIT = 0;
  localparam logic [0:0]  CTRL_RESET    = 1'h0;

  // Status register field positions.
  localparam int unsigned ST_STATE_LSB = 0;
  localparam int unsigned ST_GATE_BIT  = 7;
  localparam int unsigned ST_LIMIT_BIT = 8;
  localparam int unsigned ST_SHORT_BIT = 9;
  localparam int unsigned ST_OPEN_BIT  = 10;

  // Supervisor states, one-hot.
  typedef enum logic [6:0] {
    S_IDLE  = 7'h01,
    S_CHECK = 7'h02,
    S_ON    = 7'h04,
    S_BLANK = 7'h08,
    S_RETRY = 7'h10,
    S_STB   = 7'h20,
    S_HOT   = 7'h40
  } lsfs_state_e;

  // Comparator and control inputs of the supervisor.
  typedef struct packed {
    logic overCurrent;
    logic belowFixed;
    logic belowTrim;
    logic supplyShort;
    logic overTemp;
    logic underVolt;
    logic overVolt;
    logic shutdownRequest;
  } lsfs_sense_s;

  // Classic Wishbone request from the master.
  typedef struct packed {
    logic             cyc;
    logic             stb;
    logic             we;
    logic [ADR_W-1:0] adr;
    logic [3:0]       sel;
    logic [31:0]      dat;
  } lsfs_wb_req_s;

  // Interval timer state.
  typedef struct packed {
    logic             running;
    logic [TMR_W-1:0] count;
  } lsfs_timer_s;

endpackage

// >>> hdl/lsfs_supervisor.sv
// Fault supervisor for a high-side load switch: gate control, blanking and retry, flags.
// Assumes comparator inputs are synchronous to clk_sys and the flag pins have pull-ups.
//
// What this block does
// - Open load pulls open_load_n low while the switch stays on.
// - Fixed-threshold variant reports open load from the fixed sense comparator.
// - Open load never removes gate drive; only the listed faults do.
// - Reaching the short threshold starts the blanking timer.
// - During blanking current is limited to twice threshold, no new flag.
// - Overcurrent lasting the whole blanking interval sets short flag and turns off.
// - Overcurrent clearing early resets blanking and keeps the switch on, unflagged.
// - Blanking expiry starts the retry timer at once with the switch held off.
// - Retry expiry turns on again; cycle repeats; short flag stays low throughout.
// - Overcurrent below twice threshold still starts blanking like a full short.
// - Blanking and retry last at least their fixed minima.
// - Before each turn-on output is compared against input for supply short.
// - That check runs on every turn-on, after retry and after thermal off.
// - Failed supply-short check keeps the switch off and pulls both flags low.
// - Over-temperature turns the switch off at once, overriding everything except a shutdown request.
// - After thermal off, turn on only once the hysteretic indication clears.
// - Shutdown request high turns the device fully off.
// - Flag pair encodes normal, short, open load and supply short.
// - Undervoltage indication keeps the switch off.
// - Overvoltage indication turns the switch off at once.
//
// The Wishbone slave port and the address map were chosen for this implementation.
`timescale 1ns/1ps
module lsfs_supervisor #(
  parameter int unsigned BLANK_CYCLES = lsfs_pkg::BLANK_CYCLES,
  parameter int unsigned RETRY_CYCLES = lsfs_pkg::RETRY_CYCLES
) (
  input  wire logic                   clk_sys,
  input  wire logic                   rst,
  input  wire lsfs_pkg::lsfs_sense_s  sense,
  input  wire lsfs_pkg::lsfs_wb_req_s wbReq,
  output logic                        wbAck,
  output logic [31:0]                 wbDatOut,
  output logic                        gateOn,
  output logic                        currentLimit2x,
  output logic                        shortFaultOut,
  output logic                        shortFaultOe,
  output logic                        openLoadOut,
  output logic                        openLoadOe
);

  // Both intervals must be at least one cycle; each timer checks that its own interval fits the counter width.
  if (BLANK_CYCLES == 0 || RETRY_CYCLES == 0) begin : g_bad_cycles
    $error("Interval lengths must be at least one cycle.");
  end

  typedef struct packed {
    lsfs_pkg::lsfs_state_e state;
    logic                  shortLatch;
    logic                  gate;
    logic                  limit;
    logic                  shortOe;
    logic                  openOe;
    logic                  shortOut;
    logic                  openOut;
  } lsfs_sup_s;

  lsfs_sup_s   sup_q;
  lsfs_sup_s   sup_d;
  logic        trimSelect;
  logic        belowThreshold;
  logic        killAll;
  logic        blankStart;
  logic        blankClear;
  logic        blankExpired;
  logic        retryStart;
  logic        retryClear;
  logic        retryExpired;
  logic [31:0] statusWord;

  // Conditions that force the switch off regardless of state.
  assign killAll = sense.shutdownRequest || sense.overTemp || sense.underVolt || sense.overVolt;

  // Software picks the trimmed comparator; reset selects the fixed threshold.
  assign belowThreshold = trimSelect ? sense.belowTrim : sense.belowFixed;

  // Timer control follows state transitions computed below.
  assign blankStart = (sup_d.state == lsfs_pkg::S_BLANK) && (sup_q.state != lsfs_pkg::S_BLANK);
  assign blankClear = (sup_d.state != lsfs_pkg::S_BLANK);
  assign retryStart = (sup_d.state == lsfs_pkg::S_RETRY) && (sup_q.state != lsfs_pkg::S_RETRY);
  assign retryClear = (sup_d.state != lsfs_pkg::S_RETRY);

  // Blanking interval counter.
  lsfs_interval_timer #(
    .LOAD (BLANK_CYCLES)
  ) u_blank (
    .clk_sys (clk_sys),
    .rst     (rst),
    .start   (blankStart),
    .clear   (blankClear),
    .expired (blankExpired)
  );

  // Retry interval counter.
  lsfs_interval_timer #(
    .LOAD (RETRY_CYCLES)
  ) u_retry (
    .clk_sys (clk_sys),
    .rst     (rst),
    .start   (retryStart),
    .clear   (retryClear),
    .expired (retryExpired)
  );

  // Status readback gives software the state, gate, limit and the flag pull-down enables (high when a pin is low).
  always_comb begin
    statusWord = '0;
    statusWord[lsfs_pkg::ST_STATE_LSB +: 7] = sup_q.state;
    statusWord[lsfs_pkg::ST_GATE_BIT]       = sup_q.gate;
    statusWord[lsfs_pkg::ST_LIMIT_BIT]      = sup_q.limit;
    statusWord[lsfs_pkg::ST_SHORT_BIT]      = sup_q.shortOe;
    statusWord[lsfs_pkg::ST_OPEN_BIT]       = sup_q.openOe;
  end

  // Register slave.
  lsfs_wb_regs u_regs (
    .clk_sys    (clk_sys),
    .rst        (rst),
    .wbReq      (wbReq),
    .statusWord (statusWord),
    .wbAck      (wbAck),
    .wbDatOut   (wbDatOut),
    .trimSelect (trimSelect)
  );

  // Next-state logic. Kill conditions are checked first so no state can hold the gate
  // against them; the flag and gate outputs are derived from the next state so that
  // they change in the same cycle as the state itself.
  always_comb begin
    sup_d = sup_q;
    if (sense.shutdownRequest) begin
      sup_d.state      = lsfs_pkg::S_IDLE;
      sup_d.shortLatch = 1'b0;
    end else if (sense.overTemp) begin
      sup_d.state = lsfs_pkg::S_HOT;
    end else if (sense.underVolt || sense.overVolt) begin
      sup_d.state = lsfs_pkg::S_IDLE;
    end else begin
      unique case (sup_q.state)
        lsfs_pkg::S_IDLE: begin
          sup_d.state = lsfs_pkg::S_CHECK;
        end
        lsfs_pkg::S_CHECK: begin
          // Every turn-on passes through here with the gate still off.
          if (sense.supplyShort) begin
            sup_d.state = lsfs_pkg::S_STB;
          end else begin
            sup_d.state = lsfs_pkg::S_ON;
          end
        end
        lsfs_pkg::S_ON: begin
          // One comparator at the short threshold, whether or not the limit is reached.
          if (sense.overCurrent) begin
            sup_d.state = lsfs_pkg::S_BLANK;
          end else begin
            sup_d.shortLatch = 1'b0;
          end
        end
        lsfs_pkg::S_BLANK: begin
          if (!sense.overCurrent) begin
            sup_d.state = lsfs_pkg::S_ON;
          end else if (blankExpired) begin
            sup_d.state      = lsfs_pkg::S_RETRY;
            sup_d.shortLatch = 1'b1;
          end
        end
        lsfs_pkg::S_RETRY: begin
          if (retryExpired) begin
            sup_d.state = lsfs_pkg::S_CHECK;
          end
        end
        lsfs_pkg::S_STB: begin
          // The short is re-checked only once the comparator releases.
          if (!sense.supplyShort) begin
            sup_d.state = lsfs_pkg::S_CHECK;
          end
        end
        lsfs_pkg::S_HOT: begin
          sup_d.state = lsfs_pkg::S_CHECK;
        end
        default: begin
          sup_d.state = lsfs_pkg::S_IDLE;
        end
      endcase
    end
    // Gate drive only in on and blanking; open load cannot take it away.
    sup_d.gate  = (sup_d.state == lsfs_pkg::S_ON) || (sup_d.state == lsfs_pkg::S_BLANK);
    sup_d.limit = (sup_d.state == lsfs_pkg::S_BLANK);
    // Flag encoding: short alone, open alone, both for supply short.
    sup_d.shortOe = sup_d.shortLatch || (sup_d.state == lsfs_pkg::S_STB);
    sup_d.openOe  = (sup_d.state == lsfs_pkg::S_STB) ||
                    ((sup_d.state == lsfs_pkg::S_ON) && belowThreshold && !sup_d.shortLatch);
    sup_d.shortOut = 1'b0;
    sup_d.openOut  = 1'b0;
  end

  // State register; reset holds the switch off with both flags released.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sup_q       <= '0;
      sup_q.state <= lsfs_pkg::S_IDLE;
    end else begin
      sup_q <= sup_d;
    end
  end

  assign gateOn         = sup_q.gate;
  assign currentLimit2x = sup_q.limit;
  assign shortFaultOut  = sup_q.shortOut;
  assign shortFaultOe   = sup_q.shortOe;
  assign openLoadOut    = sup_q.openOut;
  assign openLoadOe     = sup_q.openOe;

  // Helper counter of cycles spent in retry, read only by the assertions.
  logic [31:0] retryCnt;
  always_ff @(posedge clk_sys) begin
    if (rst || sup_q.state != lsfs_pkg::S_RETRY) begin
      retryCnt <= '0;
    end else begin
      retryCnt <= retryCnt + 32'h1;
    end
  end

  a_open_keeps_gate: assert property (@(posedge clk_sys) disable iff (rst)
    (sup_q.state == lsfs_pkg::S_ON && !sense.overCurrent && !killAll) |=> gateOn)
    else $error("Open load or idle on state removed the gate.");

  a_open_flag_low: assert property (@(posedge clk_sys) disable iff (rst)
    (sup_q.state == lsfs_pkg::S_ON && !sense.overCurrent && !killAll && belowThreshold && !sup_q.shortLatch)
      |=> (openLoadOe && gateOn))
    else $error("Open load not flagged while on.");

  a_blank_start: assert property (@(posedge clk_sys) disable iff (rst)
    (sup_q.state == lsfs_pkg::S_ON && sense.overCurrent && !killAll && !sup_q.shortLatch)
      |=> (currentLimit2x && gateOn && !shortFaultOe))
    else $error("Blanking did not start cleanly.");

  a_blank_abort: assert property (@(posedge clk_sys) disable iff (rst)
    (sup_q.state == lsfs_pkg::S_BLANK && !sense.overCurrent && !killAll) |=> (sup_q.state == lsfs_pkg::S_ON))
    else $error("Blanking not aborted when overcurrent cleared.");

  a_blank_expire: assert property (@(posedge clk_sys) disable iff (rst)
    (sup_q.state == lsfs_pkg::S_BLANK && blankExpired && sense.overCurrent && !killAll)
      |=> (!gateOn && shortFaultOe && sup_q.state == lsfs_pkg::S_RETRY))
    else $error("Blanking expiry did not turn off and flag.");

  a_retry_length: assert property (@(posedge clk_sys) disable iff (rst)
    (sup_q.state == lsfs_pkg::S_RETRY && sup_d.state == lsfs_pkg::S_CHECK) |-> (retryCnt == RETRY_CYCLES - 1))
    else $error("Retry interval had the wrong length.");

  a_retry_flag: assert property (@(posedge clk_sys) disable iff (rst)
    (sup_q.state == lsfs_pkg::S_RETRY) |-> (shortFaultOe && !openLoadOe && !gateOn))
    else $error("Short flag released or gate on during retry.");

  a_check_first: assert property (@(posedge clk_sys) disable iff (rst)
    $rose(gateOn) |-> ($past(sup_q.state) == lsfs_pkg::S_CHECK))
    else $error("Switch turned on without a supply-short check.");

  a_supply_short: assert property (@(posedge clk_sys) disable iff (rst)
    (sup_q.state == lsfs_pkg::S_CHECK && sense.supplyShort && !killAll) |=> (!gateOn && shortFaultOe && openLoadOe))
    else $error("Supply short not flagged on both pins.");

  a_hot_off: assert property (@(posedge clk_sys) disable iff (rst)
    (sense.overTemp && !sense.shutdownRequest) |=> (!gateOn && sup_q.state == lsfs_pkg::S_HOT))
    else $error("Over-temperature did not turn the switch off.");

  a_shutdown_off: assert property (@(posedge clk_sys) disable iff (rst)
    sense.shutdownRequest |=> (!gateOn && !shortFaultOe && !openLoadOe && !currentLimit2x))
    else $error("Shutdown did not turn the device off.");

  a_volt_lock: assert property (@(posedge clk_sys) disable iff (rst)
    (sense.underVolt || sense.overVolt) |=> !gateOn)
    else $error("Switch on during voltage lockout.");

endmodule

// >>> hdl/lsfs_wb_regs.sv
// Wishbone classic slave holding the control register and reading back status.
// Assumes a master that holds its request until it samples ack.
`timescale 1ns/1ps
module lsfs_wb_regs (
  input  wire logic                  clk_sys,
  input  wire logic                  rst,
  input  wire lsfs_pkg::lsfs_wb_req_s wbReq,
  input  wire logic [31:0]           statusWord,
  output logic                       wbAck,
  output logic [31:0]                wbDatOut,
  output logic                       trimSelect
);

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
    logic [0:0]  ctrl;
  } lsfs_regs_s;

  lsfs_regs_s regs_q;
  lsfs_regs_s regs_d;
  logic       access;

  assign wbAck      = regs_q.ack;
  assign wbDatOut   = regs_q.dat;
  assign trimSelect = regs_q.ctrl[lsfs_pkg::CTRL_TRIM_BIT];

  // Ack one cycle after the strobe and drop it the next; unmapped reads return zero.
  always_comb begin
    regs_d     = regs_q;
    access     = wbReq.cyc && wbReq.stb && !regs_q.ack;
    regs_d.ack = access;
    regs_d.dat = '0;
    if (access && !wbReq.we) begin
      unique case (wbReq.adr)
        lsfs_pkg::ADR_CTRL:   regs_d.dat = {31'h0, regs_q.ctrl};
        lsfs_pkg::ADR_STATUS: regs_d.dat = statusWord;
        default:              regs_d.dat = '0;
      endcase
    end
    if (access && wbReq.we && wbReq.sel[0] && wbReq.adr == lsfs_pkg::ADR_CTRL) begin
      regs_d.ctrl = wbReq.dat[0:0];
    end
  end

  // State register.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      regs_q      <= '0;
      regs_q.ctrl <= lsfs_pkg::CTRL_RESET;
    end else begin
      regs_q <= regs_d;
    end
  end

endmodule

// >>> verification/lsfs_host_model.sv
// Behavioural microcontroller beside the supervisor: drives the shutdown request, reads the flags.
// Assumes pull-ups on both open-drain flag pins and a single clk_sys domain.
`timescale 1ns/1ps
module lsfs_host_model (
  input  wire logic clk_sys,
  input  wire logic enableLoad,
  input  wire logic shortFaultOe,
  input  wire logic openLoadOe,
  output logic      shutdownRequest,
  output logic      shortFaultPinN,
  output logic      openLoadPinN
);
  // Shutdown starts high so the load stays off until the bench asks for it.
  initial shutdownRequest = 1'b1;

  // Low enables the load and high shuts the device down; the host lags its command by one edge.
  always @(posedge clk_sys) begin
    shutdownRequest <= !enableLoad;
  end

  // The pull-ups take each pin high whenever the device lets go of it.
  assign shortFaultPinN = shortFaultOe ? 1'b0 : 1'b1;
  assign openLoadPinN   = openLoadOe ? 1'b0 : 1'b1;
endmodule

// >>> verification/tb_top.sv
// Self-checking bench for the load switch supervisor with short interval counts.
// Assumes one 50 MHz clock; sense inputs and bus requests change just after rising edges.
`timescale 1ns/1ps
module tb_top;
  localparam int unsigned BLANK = 8;
  localparam int unsigned RETRY = 20;

  logic                   clk_sys    = 1'b0;
  logic                   rst        = 1'b1;
  logic                   enableLoad = 1'b0;
  lsfs_pkg::lsfs_sense_s  senseDrv   = '0;
  lsfs_pkg::lsfs_sense_s  senseIn;
  lsfs_pkg::lsfs_wb_req_s wbReq      = '0;
  logic                   wbAck;
  logic [31:0]            wbDatOut;
  logic                   gateOn;
  logic                   currentLimit2x;
  logic                   shortFaultOe;
  logic                   shortFaultOut;
  logic                   openLoadOut;
  logic                   openLoadOe;
  logic                   shutdownRequest;
  logic                   shortFaultPinN;
  logic                   openLoadPinN;
  logic [31:0]            rd;
  int                     miscompares = 0;
  int                     compares    = 0;
  int                     n;

  // A 20 ns period gives the 50 MHz system clock.
  always #10 clk_sys = ~clk_sys;

  // The host model owns the shutdown line; the bench owns every comparator input.
  always_comb begin
    senseIn = senseDrv;
    senseIn.shutdownRequest = shutdownRequest;
  end

  lsfs_supervisor #(.BLANK_CYCLES(BLANK), .RETRY_CYCLES(RETRY)) lsfs_supervisor_inst (
    .clk_sys        (clk_sys),
    .rst            (rst),
    .sense          (senseIn),
    .wbReq          (wbReq),
    .wbAck          (wbAck),
    .wbDatOut       (wbDatOut),
    .gateOn         (gateOn),
    .currentLimit2x (currentLimit2x),
    .shortFaultOut  (shortFaultOut),
    .shortFaultOe   (shortFaultOe),
    .openLoadOut    (openLoadOut),
    .openLoadOe     (openLoadOe)
  );

  lsfs_host_model lsfs_host_model_inst (
    .clk_sys         (clk_sys),
    .enableLoad      (enableLoad),
    .shortFaultOe    (shortFaultOe),
    .openLoadOe      (openLoadOe),
    .shutdownRequest (shutdownRequest),
    .shortFaultPinN  (shortFaultPinN),
    .openLoadPinN    (openLoadPinN)
  );

  // Expected status word: flag nibble is {open, short, limit, gate} above the state.
  function automatic logic [31:0] st(input logic [6:0] s, input logic [3:0] f);
    st = {21'h0, f, s};
  endfunction

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Compares gate and both pin levels as one triple.
  task automatic pins(input logic [2:0] exp);
    check("gate and flag pins", {29'h0, gateOn, shortFaultPinN, openLoadPinN}, {29'h0, exp});
    // Open-drain pins only ever pull low, so the driven level must stay zero.
    check("flag drive levels", {30'h0, shortFaultOut, openLoadOut}, 32'h0);
  endtask

  // Waits k edges and then lets that edge's updates land before looking.
  task automatic tick(input int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask

  task automatic wait_gate(input logic v);
    n = 0;
    while (gateOn !== v && n < 100) begin
      tick(1);
      n++;
    end
    check("gate wait", {31'h0, gateOn}, {31'h0, v});
  endtask

  // Counts cycles while the limit is up, or while the gate is down.
  task automatic run_len(input logic lim, output int k);
    k = 0;
    while ((lim ? currentLimit2x : !gateOn) === 1'b1 && k < 1000) begin
      tick(1);
      k++;
    end
  endtask

  // Classic single cycle: hold the request until ack is high, take data, then release.
  task automatic wb_xfer(input logic we, input logic [3:0] adr, input logic [31:0] dat, output logic [31:0] q);
    int t;
    t = 0;
    @(posedge clk_sys);
    wbReq <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hf, dat: dat};
    do begin
      @(posedge clk_sys);
      #1;
      t++;
    end while (wbAck !== 1'b1 && t < 50);
    q = wbDatOut;
    @(posedge clk_sys);
    wbReq <= '0;
  endtask

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // A hang is cut short well beyond the few hundred cycles the tests need.
  initial begin
    repeat (20000) @(posedge clk_sys);
    miscompares++;
    complete_run();
  end

  // Main sequence of tests.
  initial begin
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    wb_xfer(1'b0, lsfs_pkg::ADR_STATUS, 32'h0, rd);
    check("status at reset", rd, st(lsfs_pkg::S_IDLE, 4'h0));
    pins(3'b011);
    wb_xfer(1'b0, lsfs_pkg::ADR_CTRL, 32'h0, rd);
    check("ctrl at reset", rd, 32'(lsfs_pkg::CTRL_RESET));
    @(posedge clk_sys);
    enableLoad <= 1'b1;
    wait_gate(1'b1);
    tick(2);
    pins(3'b111);
    wb_xfer(1'b0, lsfs_pkg::ADR_STATUS, 32'h0, rd);
    check("status on", rd, st(lsfs_pkg::S_ON, 4'h1));
    $display("test enable done");

    // Open load through the fixed and then the trimmed comparator.
    @(posedge clk_sys);
    senseDrv.belowFixed <= 1'b1;
    tick(2);
    pins(3'b110);
    wb_xfer(1'b1, lsfs_pkg::ADR_CTRL, 32'h1, rd);
    tick(2);
    pins(3'b111);
    wb_xfer(1'b0, lsfs_pkg::ADR_CTRL, 32'h0, rd);
    check("ctrl readback", rd, 32'h1);
    wb_xfer(1'b0, 4'h8, 32'h0, rd);
    check("unmapped read", rd, 32'h0);
    @(posedge clk_sys);
    senseDrv.belowTrim <= 1'b1;
    tick(2);
    pins(3'b110);
    wb_xfer(1'b0, lsfs_pkg::ADR_STATUS, 32'h0, rd);
    check("status open", rd, st(lsfs_pkg::S_ON, 4'h9));
    @(posedge clk_sys);
    enableLoad <= 1'b0;
    tick(3);
    pins(3'b011);
    @(posedge clk_sys);
    enableLoad <= 1'b1;
    senseDrv.belowTrim <= 1'b0;
    senseDrv.belowFixed <= 1'b0;
    wait_gate(1'b1);
    $display("test open load done");

    // A brief overcurrent is blanked and forgiven.
    @(posedge clk_sys);
    senseDrv.overCurrent <= 1'b1;
    tick(2);
    check("limit in blank", {31'h0, currentLimit2x}, 32'h1);
    pins(3'b111);
    @(posedge clk_sys);
    senseDrv.overCurrent <= 1'b0;
    tick(2);
    pins(3'b111);
    check("limit after blank", {31'h0, currentLimit2x}, 32'h0);
    $display("test brief overcurrent done");

    // A lasting short runs full blank and retry cycles; a full blank also shows the timer restarted.
    @(posedge clk_sys);
    senseDrv.overCurrent <= 1'b1;
    tick(1);
    run_len(1'b1, n);
    check("blank length", 32'(n), 32'(BLANK));
    pins(3'b001);
    run_len(1'b0, n);
    check("retry plus check length", 32'(n), 32'(RETRY + 1));
    pins(3'b101);
    tick(1);
    run_len(1'b1, n);
    check("second blank length", 32'(n), 32'(BLANK));
    pins(3'b001);
    @(posedge clk_sys);
    senseDrv.overCurrent <= 1'b0;
    senseDrv.supplyShort <= 1'b1;
    tick(RETRY + 4);
    pins(3'b000);
    wb_xfer(1'b0, lsfs_pkg::ADR_STATUS, 32'h0, rd);
    check("status supply short", rd, st(lsfs_pkg::S_STB, 4'hc));
    @(posedge clk_sys);
    senseDrv.supplyShort <= 1'b0;
    wait_gate(1'b1);
    tick(2);
    pins(3'b111);
    $display("test short circuit done");

    // Thermal off, then a supply short found on the way back on.
    @(posedge clk_sys);
    senseDrv.overTemp <= 1'b1;
    tick(1);
    pins(3'b011);
    wb_xfer(1'b0, lsfs_pkg::ADR_STATUS, 32'h0, rd);
    check("status hot", rd, st(lsfs_pkg::S_HOT, 4'h0));
    @(posedge clk_sys);
    senseDrv.overTemp <= 1'b0;
    senseDrv.supplyShort <= 1'b1;
    tick(3);
    pins(3'b000);
    @(posedge clk_sys);
    senseDrv.supplyShort <= 1'b0;
    wait_gate(1'b1);
    $display("test thermal done");

    // Under- and overvoltage each hold the switch off.
    for (int i = 0; i < 2; i++) begin
      @(posedge clk_sys);
      if (i == 0) begin
        senseDrv.underVolt <= 1'b1;
      end else begin
        senseDrv.overVolt <= 1'b1;
      end
      tick(1);
      pins(3'b011);
      tick(4);
      pins(3'b011);
      @(posedge clk_sys);
      senseDrv.underVolt <= 1'b0;
      senseDrv.overVolt <= 1'b0;
      wait_gate(1'b1);
    end
    $display("test lockout done");
    complete_run();
  end
endmodule
